// file: verilog/vga_monitor_detect_hpd.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

// Overview of operation
// - Sense load only in vertical blanking
// - Low load means connected, high disconnected
// - Connect updates sink byte 00200h; 00204h only with strap low
// - HPD interrupt only after 00200h updated
// - Policy strap sampled after initialization
// - Strap low: HPD high regardless of monitor
// - Strap high: HPD high only with monitor
// - Strap low: init low, tally, then high
// - Strap low: change sets tally, flag, pulse
// - Strap high: HPD low until monitor seen
// - Strap high: disconnect drives HPD low
// - Translate AUX I2C requests onto DDC
// - EDID bytes passed through unchanged
// - No checking of incoming video timing
// - Before link: syncs low, colours blanked
// - HPD low throughout initialization
// - Initialization disables colours, syncs low
// - Built-in reset then initialization sequence
// - Own timing and 8-bit DAC values
module vga_monitor_detect_hpd #(
    parameter int unsigned INIT_CYCLES = vga_detect_pkg::INIT_CYCLES,
    parameter int unsigned IRQ_CYCLES  = vga_detect_pkg::IRQ_PULSE_CYCLES,
    parameter int unsigned DDC_QUARTER = vga_detect_pkg::DDC_QUARTER
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [19:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        hpd_policy_strap,
    input  wire logic        load_sense_low,
    input  wire logic        link_up,
    input  wire logic [7:0]  vid_red,
    input  wire logic [7:0]  vid_grn,
    input  wire logic [7:0]  vid_blu,
    input  wire logic        vid_hsync,
    input  wire logic        vid_vsync,
    input  wire logic        vid_hblank,
    input  wire logic        vid_vblank,
    output logic      [7:0]  dac_red,
    output logic      [7:0]  dac_grn,
    output logic      [7:0]  dac_blu,
    output logic             dac_enable,
    output logic             hsync_out,
    output logic             vsync_out,
    output logic             hpd,
    input  wire logic        aux_req_valid,
    input  wire logic        aux_req_read,
    input  wire logic [6:0]  aux_req_addr,
    input  wire logic [7:0]  aux_req_data,
    output logic             aux_defer,
    output logic             aux_rsp_valid,
    output logic      [7:0]  aux_rsp_data,
    output logic             aux_rsp_nack,
    input  wire logic        ddc_scl_i,
    output logic             ddc_scl_o,
    output logic             ddc_scl_oe,
    input  wire logic        ddc_sda_i,
    output logic             ddc_sda_o,
    output logic             ddc_sda_oe
);
    localparam int unsigned INIT_W = $clog2(INIT_CYCLES + 1);
    localparam int unsigned IRQ_W  = $clog2(IRQ_CYCLES + 1);
    localparam int unsigned DIV_W  = $clog2(DDC_QUARTER + 1);
    localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);
    localparam logic [IRQ_W-1:0]  IRQ_LEN   = IRQ_W'(IRQ_CYCLES);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(DDC_QUARTER - 1);

    // --------------------
    // Monitor presence
    // --------------------
    logic sense_connected;
    logic sense_change;

    load_sense_filter #(
        .STABLE_MEAS    (vga_detect_pkg::STABLE_MEAS)
    ) u_sense (
        .ref_clk        (ref_clk),
        .reset_n        (reset_n),
        .vblank         (vid_vblank),
        .hblank         (vid_hblank),
        .sense_low_load (load_sense_low),
        .connected      (sense_connected),
        .change         (sense_change)
    );

    // --------------------
    // Power-up sequence
    // --------------------
    vga_detect_pkg::init_state_t state_reg;
    vga_detect_pkg::init_state_t state_next;
    logic [INIT_W-1:0]           init_cnt_reg;
    logic                        strap_reg;
    wire                         running;

    assign running = (state_reg == vga_detect_pkg::ST_RUN);

    // Steps through reset and initialization with no outside help
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            vga_detect_pkg::ST_RESET: state_next = vga_detect_pkg::ST_INIT;
            vga_detect_pkg::ST_INIT:
                if (init_cnt_reg == INIT_LAST)
                    state_next = vga_detect_pkg::ST_SYNC;
            vga_detect_pkg::ST_SYNC:  state_next = vga_detect_pkg::ST_RUN;
            vga_detect_pkg::ST_RUN:   state_next = vga_detect_pkg::ST_RUN;
            default:                  state_next = vga_detect_pkg::ST_RESET;
        endcase
    end

    // Sequence state and init timer
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg    <= vga_detect_pkg::ST_RESET;
            init_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == vga_detect_pkg::ST_INIT)
                init_cnt_reg <= init_cnt_reg + 1'b1;
        end
    end

    // Strap caught by the clock once initialization ends, not by reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            strap_reg <= 1'b0;
        else if (state_reg == vga_detect_pkg::ST_SYNC)
            strap_reg <= hpd_policy_strap;
    end

    // --------------------
    // Sink status bytes and hot-plug signalling
    // --------------------
    logic             sink_count_reg;
    logic             port_change_reg;
    logic             irq_req_reg;
    logic [IRQ_W-1:0] irq_cnt_reg;
    logic             hpd_reg;
    logic [7:0]       control_reg;
    wire              sink_update;
    wire              change_set;
    wire              change_clear;
    wire              irq_active;
    wire              hpd_next;

    // Tally loads at the end of init and on every filtered change
    assign sink_update  = (state_reg == vga_detect_pkg::ST_SYNC) | (running & sense_change);
    assign change_set   = running & sense_change & ~strap_reg;
    assign change_clear = reg_wr & (reg_addr == vga_detect_pkg::SINK_STATUS_ADDR)
                          & reg_wdata[vga_detect_pkg::PORT_CHANGE_BIT];
    assign irq_active   = (irq_cnt_reg != '0);
    // Low strap: high whatever the tally; high strap: follows the tally
    assign hpd_next     = running & ~irq_active
                          & (strap_reg ? sink_count_reg : 1'b1);

    // Status bytes; a change in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sink_count_reg  <= 1'b0;
            port_change_reg <= 1'b0;
        end
        else
        begin
            if (sink_update)
                sink_count_reg <= sense_connected;
            if (change_set)
                port_change_reg <= 1'b1;
            else if (change_clear)
                port_change_reg <= 1'b0;
        end
    end

    // Pulse starts the cycle after the tally byte has moved
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_req_reg <= 1'b0;
            irq_cnt_reg <= '0;
            hpd_reg     <= 1'b0;
        end
        else
        begin
            irq_req_reg <= change_set;
            if (irq_req_reg)
                irq_cnt_reg <= IRQ_LEN;
            else if (irq_active)
                irq_cnt_reg <= irq_cnt_reg - 1'b1;
            hpd_reg <= hpd_next;
        end
    end

    assign hpd = hpd_reg;

    // --------------------
    // Video output gating
    // --------------------
    logic [7:0] dac_red_reg;
    logic [7:0] dac_grn_reg;
    logic [7:0] dac_blu_reg;
    logic       dac_enable_reg;
    logic       hsync_reg;
    logic       vsync_reg;
    wire        blank;

    // Timing is forwarded as sent; no mode check is attempted
    assign blank = ~running | ~link_up | control_reg[vga_detect_pkg::CTRL_BLANK_BIT];

    // Colours and syncs held at zero until the link is up
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dac_red_reg    <= 8'h00;
            dac_grn_reg    <= 8'h00;
            dac_blu_reg    <= 8'h00;
            dac_enable_reg <= 1'b0;
            hsync_reg      <= 1'b0;
            vsync_reg      <= 1'b0;
        end
        else
        begin
            dac_red_reg    <= blank ? 8'h00 : vid_red;
            dac_grn_reg    <= blank ? 8'h00 : vid_grn;
            dac_blu_reg    <= blank ? 8'h00 : vid_blu;
            dac_enable_reg <= ~blank;
            hsync_reg      <= ~blank & vid_hsync;
            vsync_reg      <= ~blank & vid_vsync;
        end
    end

    assign dac_red    = dac_red_reg;
    assign dac_grn    = dac_grn_reg;
    assign dac_blu    = dac_blu_reg;
    assign dac_enable = dac_enable_reg;
    assign hsync_out  = hsync_reg;
    assign vsync_out  = vsync_reg;

    // --------------------
    // DDC bridge: one byte per request, no caching
    // --------------------
    logic             ddc_busy_reg;
    logic [4:0]       step_reg;
    logic [1:0]       qtr_reg;
    logic [DIV_W-1:0] div_reg;
    logic [7:0]       shift_reg;
    logic [7:0]       rx_reg;
    logic             read_reg;
    logic [7:0]       wbyte_reg;
    logic             nack_reg;
    logic             scl_low_reg;
    logic             sda_low_reg;
    logic             rsp_valid_reg;
    wire              tick;
    wire              is_start;
    wire              is_stop;
    wire              is_ack;
    wire              in_data;
    wire              scl_low;
    wire              sda_low;

    assign tick     = ddc_busy_reg & (div_reg == DIV_LAST);
    assign is_start = (step_reg == vga_detect_pkg::STEP_START);
    assign is_stop  = (step_reg == vga_detect_pkg::STEP_STOP);
    assign is_ack   = (step_reg == vga_detect_pkg::STEP_ADDR_ACK)
                      | (step_reg == vga_detect_pkg::STEP_DATA_ACK);
    assign in_data  = (step_reg > vga_detect_pkg::STEP_ADDR_ACK)
                      & (step_reg < vga_detect_pkg::STEP_DATA_ACK);
    // Clock low in first and last quarter of each bit, data set while low
    assign scl_low  = ddc_busy_reg & (is_start ? (qtr_reg == 2'd3) :
                      is_stop ? (qtr_reg == 2'd0) : (qtr_reg == 2'd0) | (qtr_reg == 2'd3));
    // Acks are always released: the master ends every read with a NACK
    assign sda_low  = ddc_busy_reg & (is_start ? qtr_reg[1] :
                      is_stop ? ~qtr_reg[1] : ~is_ack & ~shift_reg[7]);

    // Bit engine of the open-drain DDC master
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ddc_busy_reg  <= 1'b0;
            step_reg      <= 5'h00;
            qtr_reg       <= 2'd0;
            div_reg       <= '0;
            shift_reg     <= 8'hff;
            rx_reg        <= 8'h00;
            read_reg      <= 1'b0;
            wbyte_reg     <= 8'h00;
            nack_reg      <= 1'b0;
            rsp_valid_reg <= 1'b0;
        end
        else
        begin
            rsp_valid_reg <= 1'b0;
            if (!ddc_busy_reg)
            begin
                if (aux_req_valid)
                begin
                    ddc_busy_reg <= 1'b1;
                    step_reg     <= vga_detect_pkg::STEP_START;
                    qtr_reg      <= 2'd0;
                    div_reg      <= '0;
                    shift_reg    <= {aux_req_addr, aux_req_read};
                    read_reg     <= aux_req_read;
                    wbyte_reg    <= aux_req_data;
                    nack_reg     <= 1'b0;
                end
            end
            else if (tick)
            begin
                div_reg <= '0;
                qtr_reg <= qtr_reg + 2'd1;
                if (qtr_reg == 2'd2)
                begin
                    if (in_data)
                        rx_reg <= {rx_reg[6:0], ddc_sda_i};
                    if (is_ack && !(read_reg && step_reg == vga_detect_pkg::STEP_DATA_ACK))
                        nack_reg <= nack_reg | ddc_sda_i;
                end
                if (qtr_reg == 2'd3)
                begin
                    step_reg <= step_reg + 5'h01;
                    if (step_reg == vga_detect_pkg::STEP_ADDR_ACK)
                        shift_reg <= read_reg ? 8'hff : wbyte_reg;
                    else if (!is_start)
                        shift_reg <= {shift_reg[6:0], 1'b1};
                    if (is_stop)
                    begin
                        ddc_busy_reg  <= 1'b0;
                        rsp_valid_reg <= 1'b1;
                    end
                end
            end
            else
                div_reg <= div_reg + 1'b1;
        end
    end

    // Line drivers registered so the pins never glitch
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end
        else
        begin
            scl_low_reg <= scl_low;
            sda_low_reg <= sda_low;
        end
    end

    assign ddc_scl_o     = 1'b0;
    assign ddc_scl_oe    = scl_low_reg;
    assign ddc_sda_o     = 1'b0;
    assign ddc_sda_oe    = sda_low_reg;
    assign aux_defer     = ddc_busy_reg;
    assign aux_rsp_valid = rsp_valid_reg;
    assign aux_rsp_data  = rx_reg;
    assign aux_rsp_nack  = nack_reg;

    // --------------------
    // Register port
    // --------------------
    logic [7:0] rdata_reg;
    logic [7:0] status_value;
    logic [7:0] rd_value;

    assign status_value = {3'b000, running, ddc_busy_reg, sense_connected, strap_reg, hpd_reg};
    // Unmapped addresses read as zero
    assign rd_value =
        (reg_addr == vga_detect_pkg::SINK_COUNT_ADDR)  ? {7'h00, sink_count_reg} :
        (reg_addr == vga_detect_pkg::SINK_STATUS_ADDR) ? {1'b0, port_change_reg, 6'h00} :
        (reg_addr == vga_detect_pkg::STATUS_ADDR)      ? status_value :
        (reg_addr == vga_detect_pkg::CONTROL_ADDR)     ? control_reg : 8'h00;

    // Control write and read data, the latter valid one cycle later
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            control_reg <= vga_detect_pkg::CONTROL_RESET;
            rdata_reg   <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == vga_detect_pkg::CONTROL_ADDR)
                control_reg <= reg_wdata;
            rdata_reg <= reg_rd ? rd_value : 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// file: include/vga_detect_pkg.sv
package vga_detect_pkg;

    // --------------------
    // Register map (8-bit registers on a 20-bit address port)
    // --------------------
    localparam int unsigned ADDR_W           = 20;
    localparam int unsigned DATA_W           = 8;
    localparam logic [19:0] SINK_COUNT_ADDR  = 20'h00200;
    localparam logic [19:0] SINK_STATUS_ADDR = 20'h00204;
    localparam logic [19:0] STATUS_ADDR      = 20'h00210;
    localparam logic [19:0] CONTROL_ADDR     = 20'h00214;

    // Field positions
    localparam int unsigned SINK_COUNT_BIT   = 0;
    localparam int unsigned PORT_CHANGE_BIT  = 6;
    localparam int unsigned STAT_HPD_BIT     = 0;
    localparam int unsigned STAT_STRAP_BIT   = 1;
    localparam int unsigned STAT_CONN_BIT    = 2;
    localparam int unsigned STAT_DDC_BIT     = 3;
    localparam int unsigned STAT_RUN_BIT     = 4;
    localparam int unsigned CTRL_BLANK_BIT   = 0;

    // Reset values
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;
    localparam logic [7:0]  SINK_RESET       = 8'h00;

    // --------------------
    // Timing
    // --------------------
    localparam int unsigned CLK_PERIOD_PS    = 25000;
    localparam int unsigned IRQ_PULSE_US     = 750;
    localparam int unsigned IRQ_PULSE_CYCLES = IRQ_PULSE_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned INIT_TIME_US     = 1000;
    localparam int unsigned INIT_CYCLES      = INIT_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned DDC_RATE_KHZ     = 100;
    localparam int unsigned DDC_QUARTER      = (1000000000 / DDC_RATE_KHZ) / CLK_PERIOD_PS / 4;
    localparam int unsigned STABLE_MEAS      = 2;

    // DDC transaction steps: start, 8 address bits, ack, 8 data bits, ack, stop
    localparam logic [4:0]  STEP_START       = 5'h00;
    localparam logic [4:0]  STEP_ADDR_ACK    = 5'h09;
    localparam logic [4:0]  STEP_DATA_ACK    = 5'h12;
    localparam logic [4:0]  STEP_STOP        = 5'h13;

    // Power-up sequence, Gray coded
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT  = 2'b01,
        ST_SYNC  = 2'b11,
        ST_RUN   = 2'b10
    } init_state_t;

endpackage

// file: verilog/load_sense_filter.sv
`timescale 1ns/1ps

module load_sense_filter #(
    parameter int unsigned STABLE_MEAS = vga_detect_pkg::STABLE_MEAS
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic vblank,
    input  wire logic hblank,
    input  wire logic sense_low_load,
    output logic      connected,
    output logic      change
);
    localparam int unsigned CNT_W = $clog2(STABLE_MEAS + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(STABLE_MEAS);

    logic             vblank_prev_reg;
    logic             last_reg;
    logic [CNT_W-1:0] run_reg;
    logic [CNT_W-1:0] run_next;
    logic             connected_reg;
    logic             change_reg;
    wire              measure;
    wire              stable;

    // At most one sample per frame, at the start of vertical blanking and only with hblank low
    assign measure  = vblank & ~vblank_prev_reg & ~hblank;
    assign run_next = (sense_low_load == last_reg) ?
                      ((run_reg == CNT_MAX) ? CNT_MAX : run_reg + 1'b1) : CNT_W'(1);
    // Low load (double termination) means a monitor hangs on the cable
    assign stable   = measure && (run_next >= CNT_MAX)
                      && (sense_low_load != connected_reg);

    // Filter state; a single glitchy frame never flips the result
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vblank_prev_reg <= 1'b0;
            last_reg        <= 1'b0;
            run_reg         <= '0;
            connected_reg   <= 1'b0;
            change_reg      <= 1'b0;
        end
        else
        begin
            vblank_prev_reg <= vblank;
            change_reg      <= stable;
            if (measure)
            begin
                last_reg <= sense_low_load;
                run_reg  <= run_next;
            end
            if (stable)
                connected_reg <= sense_low_load;
        end
    end

    assign connected = connected_reg;
    assign change    = change_reg;

endmodule

// file: verification/vga_detect_asserts.sv
`timescale 1ns/1ps

module vga_detect_asserts #(
    parameter int unsigned INIT_CYCLES = 20,
    parameter int unsigned IRQ_CYCLES  = 10
) (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       link_up,
    input wire logic [7:0] vid_red,
    input wire logic       vid_hsync,
    input wire logic       hpd_policy_strap,
    input wire logic       load_sense_low,
    input wire logic [7:0] dac_red,
    input wire logic       dac_enable,
    input wire logic       hsync_out,
    input wire logic       vsync_out,
    input wire logic       hpd,
    input wire logic       aux_req_valid,
    input wire logic       aux_defer,
    input wire logic       aux_rsp_valid
);
    // --------------------
    // History
    // --------------------
    int   age;
    int   low_cnt;
    logic seen_load;
    logic seen_high;

    // Saturating age, so a long run cannot wrap back into the init window
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            age       <= 0;
            low_cnt   <= 0;
            seen_load <= 1'b0;
            seen_high <= 1'b0;
        end
        else
        begin
            age       <= (age < 1000) ? age + 1 : age;
            low_cnt   <= hpd ? 0 : low_cnt + 1;
            seen_load <= seen_load | load_sense_low;
            seen_high <= seen_high | hpd;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // --------------------
    // Properties
    // --------------------
    hpd_init_low_a: assert property (age < INIT_CYCLES |-> !hpd)
        else $error("hpd high during init");
    init_dark_a: assert property (age < INIT_CYCLES |-> !dac_enable && !hsync_out)
        else $error("outputs live during init");
    link_blank_a: assert property (!link_up |=> !hsync_out && !vsync_out && dac_red == 8'h00)
        else $error("outputs live without link");
    video_pass_a: assert property (dac_enable |-> dac_red == $past(vid_red)
        && hsync_out == $past(vid_hsync))
        else $error("colour not passed");
    defer_raise_a: assert property (aux_req_valid && !aux_defer |=> aux_defer)
        else $error("no defer after request");
    aux_reply_a: assert property (aux_req_valid && !aux_defer |-> ##[2:170] aux_rsp_valid)
        else $error("no reply in time");
    strap_hold_a: assert property (hpd_policy_strap && !seen_load |-> !hpd)
        else $error("hpd high with no monitor");
    irq_width_a: assert property ($rose(hpd) && seen_high && !hpd_policy_strap
        |-> low_cnt == IRQ_CYCLES)
        else $error("irq pulse width wrong");
endmodule

bind vga_monitor_detect_hpd vga_detect_asserts #(
    .INIT_CYCLES(INIT_CYCLES),
    .IRQ_CYCLES (IRQ_CYCLES)
) vga_detect_asserts_i (.ref_clk, .reset_n, .link_up, .vid_red, .vid_hsync,
    .hpd_policy_strap, .load_sense_low, .dac_red, .dac_enable, .hsync_out,
    .vsync_out, .hpd, .aux_req_valid, .aux_defer, .aux_rsp_valid);

// file: verification/ddc_monitor_model.sv
`timescale 1ns/1ps

// One-byte display memory on the pulled-up DDC wires
module ddc_monitor_model #(
    parameter logic [6:0] DEV_ADDR   = 7'h50,
    parameter logic [7:0] FIRST_BYTE = 8'ha5
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_pull
);
    logic [7:0] sh;
    logic [7:0] mem;
    logic       rd;
    logic       sel;
    int         bitn;

    initial
    begin
        sda_pull = 1'b0;
        bitn     = -1;
        mem      = FIRST_BYTE;
        sel      = 1'b0;
    end

    // Start and stop only count while the clock line is high
    always @(negedge sda) if (scl) bitn = 0;
    always @(posedge sda) if (scl) bitn = -1;
    always @(posedge scl) if (bitn >= 0) {sh, bitn} = {sh[6:0], sda, bitn + 1};

    // Change the pull only while the clock is low, as a real slave must
    always @(negedge scl)
    begin
        sda_pull = 1'b0;
        if (bitn == 8)
        begin
            sel      = (sh[7:1] == DEV_ADDR);
            rd       = sh[0];
            sda_pull = sel;
        end
        else if (sel && rd && bitn >= 9 && bitn <= 16)
            sda_pull = !mem[16 - bitn];
        else if (sel && !rd && bitn == 17)
        begin
            mem      = sh;
            sda_pull = 1'b1;
        end
    end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps

module tb;
    logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, hpd_policy_strap = 0;
    logic load_sense_low = 1, link_up = 0, vid_hsync = 0, vid_vsync = 0;
    logic vid_hblank = 0, vid_vblank = 0, aux_req_valid = 0, aux_req_read = 0;
    logic [19:0] reg_addr = '0;
    logic [7:0]  reg_wdata = '0, vid_red = '0, vid_grn = '0, vid_blu = '0, aux_req_data = '0;
    logic [6:0]  aux_req_addr = '0;
    logic [7:0]  reg_rdata, dac_red, dac_grn, dac_blu, aux_rsp_data;
    logic        dac_enable, hsync_out, vsync_out, hpd, aux_defer, aux_rsp_valid, ddc_sda_o;
    logic        aux_rsp_nack, ddc_scl_oe, ddc_sda_oe, pull, ddc_scl_i, ddc_sda_i, ddc_scl_o;
    int          err_total = 0, checks = 0;

    always #12.5 ref_clk = ~ref_clk;
    // Open-drain wires with pull-ups
    assign ddc_scl_i = !ddc_scl_oe | ddc_scl_o;
    assign ddc_sda_i = (!ddc_sda_oe | ddc_sda_o) & !pull;

    vga_monitor_detect_hpd #(.INIT_CYCLES(20), .IRQ_CYCLES(10), .DDC_QUARTER(2))
    vga_monitor_detect_hpd_i (.*);

    ddc_monitor_model ddc_monitor_model_i (.scl(ddc_scl_i), .sda(ddc_sda_i), .sda_pull(pull));

    // --------------------
    // Tasks
    // --------------------
    task automatic wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %0t: saw %h want %h", $time, s, e);
        end
    endtask

    // Every wait is capped; running out ends the run as a failure
    task automatic tmo(input int i);
        if (i == 200)
        begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge ref_clk);
    endtask

    task automatic hpd_wait(input logic v);
        int i;
        for (i = 0; i < 200 && hpd !== v; i++)
            @(negedge ref_clk);
        tmo(i);
        @(posedge ref_clk);
    endtask

    // One vertical blanking pulse; measured only when hb is low
    task automatic vb(input logic hb);
        vid_hblank <= hb;
        vid_vblank <= 1'b1;
        @(posedge ref_clk);
        vid_vblank <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic aux(input logic r, input logic [6:0] a, input logic [7:0] d, input logic n);
        int i;
        aux_req_read  <= r;
        aux_req_addr  <= a;
        aux_req_data  <= d;
        aux_req_valid <= 1'b1;
        @(posedge ref_clk);
        aux_req_valid <= 1'b0;
        for (i = 0; i < 200 && aux_rsp_valid !== 1'b1; i++)
            @(negedge ref_clk);
        tmo(i);
        @(posedge ref_clk);
        chk({7'h0, aux_rsp_nack}, {7'h0, n});
        if (r && !n)
            chk(aux_rsp_data, d);
    endtask

    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        vb(1'b0);
        vb(1'b0);
        hpd_wait(1'b1);
        rd(20'h00200, 8'h01);
        rd(20'h00204, 8'h00);
        rd(20'h00210, 8'h15);
        rd(20'h00300, 8'h00);
        wr(20'h00200, 8'hff);
        rd(20'h00200, 8'h01);
        vid_red   <= 8'h5a;
        vid_grn   <= 8'h3c;
        vid_blu   <= 8'hc3;
        vid_hsync <= 1'b1;
        vid_vsync <= 1'b1;
        link_up   <= 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(dac_red, 8'h5a);
        chk(dac_grn, 8'h3c);
        chk(dac_blu, 8'hc3);
        @(posedge ref_clk);
        wr(20'h00214, 8'h01);
        repeat (2) @(negedge ref_clk);
        chk({7'h0, dac_enable}, 8'h00);
        @(posedge ref_clk);
        load_sense_low <= 1'b0;
        vb(1'b1);
        vb(1'b1);
        vb(1'b0);
        rd(20'h00200, 8'h01);
        vb(1'b0);
        hpd_wait(1'b0);
        hpd_wait(1'b1);
        rd(20'h00200, 8'h00);
        rd(20'h00204, 8'h40);
        wr(20'h00204, 8'h40);
        rd(20'h00204, 8'h00);
        aux(1'b1, 7'h50, 8'ha5, 1'b0);
        aux(1'b0, 7'h50, 8'h3c, 1'b0);
        aux(1'b1, 7'h50, 8'h3c, 1'b0);
        aux(1'b1, 7'h51, 8'h00, 1'b1);
        reset_n          <= 1'b0;
        hpd_policy_strap <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (40) @(posedge ref_clk);
        hpd_wait(1'b0);
        rd(20'h00210, 8'h12);
        load_sense_low <= 1'b1;
        vb(1'b0);
        vb(1'b0);
        hpd_wait(1'b1);
        load_sense_low <= 1'b0;
        vb(1'b0);
        vb(1'b0);
        hpd_wait(1'b0);
        wrap_up();
    end
endmodule
